// *** rtl/ccr_i2c_slave.sv ***
// serial bus slave: pointer byte then auto-incrementing data bytes
module ccr_i2c_slave
   import ccr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n,
   // register side
   output logic [7:0]      reg_ptr,
   output logic            wr_stb,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data
);

   logic           scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
   logic           scl_prev_q, sda_prev_q;
   ccr_i2c_state_t st_q, st_d;
   logic [7:0]     sh_q, sh_d, ptr_q, ptr_d;
   logic [3:0]     cnt_q, cnt_d;
   logic           oe_n_q, oe_n_d, ack_q, ack_d, wr_q, wr_d;
   logic           scl_rise, scl_fall, start, stop;

   assign scl_rise = scl_s2_q & ~scl_prev_q;
   assign scl_fall = ~scl_s2_q & scl_prev_q;
   assign start    = scl_s2_q & scl_prev_q & ~sda_s2_q & sda_prev_q;
   assign stop     = scl_s2_q & scl_prev_q & sda_s2_q & ~sda_prev_q;

   always_comb begin
      st_d   = st_q;
      sh_d   = sh_q;
      ptr_d  = ptr_q;
      cnt_d  = cnt_q;
      oe_n_d = oe_n_q;
      ack_d  = ack_q;
      wr_d   = 1'b0;
      if (start) begin
         st_d   = CCR_I2C_ADDR;
         cnt_d  = '0;
         oe_n_d = 1'b1;
      end else if (stop) begin
         st_d   = CCR_I2C_IDLE;
         oe_n_d = 1'b1;
      end else if (scl_rise) begin
         case (st_q)
            CCR_I2C_ADDR, CCR_I2C_PTR, CCR_I2C_WDATA: begin
               sh_d  = {sh_q[6:0], sda_s2_q};
               cnt_d = cnt_q + 4'h1;
            end
            CCR_I2C_RDATA: begin
               sh_d  = {sh_q[6:0], 1'b0};
               cnt_d = cnt_q + 4'h1;
            end
            CCR_I2C_RDATA_ACK: begin
               ack_d = ~sda_s2_q;
               ptr_d = ptr_q + 8'h01;
            end
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_q)
            CCR_I2C_ADDR: begin
               if (cnt_q == 4'h8) begin
                  if (sh_q[7:1] == CCR_DEV_ADDR) begin
                     st_d   = CCR_I2C_ADDR_ACK;
                     oe_n_d = 1'b0;
                  end else begin
                     st_d = CCR_I2C_IDLE;
                  end
               end
            end
            CCR_I2C_ADDR_ACK: begin
               cnt_d = '0;
               if (sh_q[0]) begin
                  // read: first data bit goes out on this falling edge
                  st_d   = CCR_I2C_RDATA;
                  sh_d   = rd_data;
                  oe_n_d = rd_data[7];
               end else begin
                  st_d   = CCR_I2C_PTR;
                  oe_n_d = 1'b1;
               end
            end
            CCR_I2C_PTR, CCR_I2C_WDATA: begin
               if (cnt_q == 4'h8) begin
                  oe_n_d = 1'b0;
                  if (st_q == CCR_I2C_PTR) begin
                     ptr_d = sh_q;
                     st_d  = CCR_I2C_PTR_ACK;
                  end else begin
                     wr_d = 1'b1;
                     st_d = CCR_I2C_WDATA_ACK;
                  end
               end
            end
            CCR_I2C_PTR_ACK, CCR_I2C_WDATA_ACK: begin
               if (st_q == CCR_I2C_WDATA_ACK) begin
                  ptr_d = ptr_q + 8'h01;
               end
               st_d   = CCR_I2C_WDATA;
               cnt_d  = '0;
               oe_n_d = 1'b1;
            end
            CCR_I2C_RDATA: begin
               if (cnt_q == 4'h8) begin
                  st_d   = CCR_I2C_RDATA_ACK;
                  oe_n_d = 1'b1;
               end else begin
                  oe_n_d = sh_q[7];
               end
            end
            CCR_I2C_RDATA_ACK: begin
               cnt_d = '0;
               if (ack_q) begin
                  st_d   = CCR_I2C_RDATA;
                  sh_d   = rd_data;
                  oe_n_d = rd_data[7];
               end else begin
                  st_d = CCR_I2C_IDLE;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1_q   <= 1'b1;
         scl_s2_q   <= 1'b1;
         sda_s1_q   <= 1'b1;
         sda_s2_q   <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         st_q       <= CCR_I2C_IDLE;
         sh_q       <= 8'h00;
         ptr_q      <= 8'h00;
         cnt_q      <= 4'h0;
         oe_n_q     <= 1'b1;
         ack_q      <= 1'b0;
         wr_q       <= 1'b0;
      end else begin
         scl_s1_q   <= scl_i;
         scl_s2_q   <= scl_s1_q;
         sda_s1_q   <= sda_i;
         sda_s2_q   <= sda_s1_q;
         scl_prev_q <= scl_s2_q;
         sda_prev_q <= sda_s2_q;
         st_q       <= st_d;
         sh_q       <= sh_d;
         ptr_q      <= ptr_d;
         cnt_q      <= cnt_d;
         oe_n_q     <= oe_n_d;
         ack_q      <= ack_d;
         wr_q       <= wr_d;
      end
   end

   // open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_n = oe_n_q;
   assign reg_ptr  = ptr_q;
   assign wr_stb   = wr_q;
   assign wr_data  = sh_q;

endmodule

// *** rtl/ccr_pkg.sv ***
// constants for the charger control register bank
package ccr_pkg;

   // register offsets on the serial bus
   localparam logic [7:0] CCR_OFS_CTRL0 = 8'h0f;
   localparam logic [7:0] CCR_OFS_CTRL1 = 8'h10;
   localparam logic [7:0] CCR_OFS_CTRL2 = 8'h11;

   // reset values
   localparam logic [7:0] CCR_RST_CTRL0 = 8'ha2;
   localparam logic [7:0] CCR_RST_CTRL1 = 8'h85;
   localparam logic [7:0] CCR_RST_CTRL2 = 8'h40;

   // writable bits; reserved bits read as zero
   localparam logic [7:0] CCR_WMASK_CTRL0 = 8'hfe;
   localparam logic [7:0] CCR_WMASK_CTRL1 = 8'h3f;
   localparam logic [7:0] CCR_WMASK_CTRL2 = 8'hff;

   // control 0 fields
   localparam int CCR_B_AUTO_DISCHG  = 7;
   localparam int CCR_B_FORCE_DISCHG = 6;
   localparam int CCR_B_CHG_EN       = 5;
   localparam int CCR_B_ICO_EN       = 4;
   localparam int CCR_B_ICO_FORCE    = 3;
   localparam int CCR_B_HIZ_EN       = 2;
   localparam int CCR_B_TERM_EN      = 1;

   // control 1 fields
   localparam int CCR_B_OVP_LO  = 4;
   localparam int CCR_B_WD_KICK = 3;
   localparam int CCR_B_WD_LO   = 0;

   // control 2 fields
   localparam int CCR_B_DET_FORCE = 7;
   localparam int CCR_B_DET_AUTO  = 6;
   localparam int CCR_B_HV_12V    = 5;
   localparam int CCR_B_HV_9V     = 4;
   localparam int CCR_B_HV_EN     = 3;
   localparam int CCR_B_SHIP_LO   = 1;
   localparam int CCR_B_SHIP_SKIP = 0;

   // input over-voltage threshold codes
   localparam logic [1:0] CCR_OVP_26V = 2'h0;
   localparam logic [1:0] CCR_OVP_22V = 2'h1;
   localparam logic [1:0] CCR_OVP_12V = 2'h2;
   localparam logic [1:0] CCR_OVP_7V  = 2'h3;

   // ship fet commands
   localparam logic [1:0] CCR_SHIP_IDLE     = 2'h0;
   localparam logic [1:0] CCR_SHIP_SHUTDOWN = 2'h1;
   localparam logic [1:0] CCR_SHIP_SHIP     = 2'h2;
   localparam logic [1:0] CCR_SHIP_SYS_RST  = 2'h3;

   // timing: 125 MHz clock, slow timers count half-second ticks
   localparam int CCR_CLK_KHZ         = 125000;
   localparam int CCR_TICK_MS         = 500;
   localparam int CCR_TICK_CYCLES     = CCR_TICK_MS * CCR_CLK_KHZ;
   localparam int CCR_SHIP_DELAY_MS   = 10000;
   localparam int CCR_SHIP_DELAY_TICK = CCR_SHIP_DELAY_MS / CCR_TICK_MS;
   localparam int CCR_WD_PERIOD_MS [8] = '{0, 500, 1000, 2000, 20000, 40000, 80000, 160000};
   localparam int CCR_TMR_W           = 9;

   // bus address of the device, value arbitrary
   localparam logic [6:0] CCR_DEV_ADDR = 7'h2a;

   typedef enum {
      CCR_I2C_IDLE, CCR_I2C_ADDR, CCR_I2C_ADDR_ACK, CCR_I2C_PTR, CCR_I2C_PTR_ACK,
      CCR_I2C_WDATA, CCR_I2C_WDATA_ACK, CCR_I2C_RDATA, CCR_I2C_RDATA_ACK
   } ccr_i2c_state_t;

endpackage

// *** rtl/ccr_timer.sv ***
// half-second tick countdown timer with one-cycle expiry pulse
module ccr_timer
   import ccr_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // control
   input  wire logic                 tick,
   input  wire logic                 load,
   input  wire logic [CCR_TMR_W-1:0] load_val,
   // result
   output logic                      expire
);

   logic [CCR_TMR_W-1:0] cnt_q, cnt_d;
   logic                 armed_q, armed_d;
   logic                 exp_q, exp_d;

   // a zero load value leaves the timer stopped
   always_comb begin
      cnt_d   = cnt_q;
      armed_d = armed_q;
      exp_d   = 1'b0;
      if (load) begin
         cnt_d   = load_val;
         armed_d = (load_val != '0);
      end else if (armed_q && tick) begin
         if (cnt_q == CCR_TMR_W'(1)) begin
            exp_d   = 1'b1;
            armed_d = 1'b0;
         end else begin
            cnt_d = cnt_q - CCR_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= '0;
         armed_q <= 1'b0;
         exp_q   <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         armed_q <= armed_d;
         exp_q   <= exp_d;
      end
   end

   assign expire = exp_q;

endmodule

// *** rtl/ccr_top.sv ***
// charger control registers: three control bytes with their self-clearing actions
module ccr_top
   import ccr_pkg::*;
#(
   parameter int TICK_CYCLES = CCR_TICK_CYCLES
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // serial bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_n,
   // analog status pins
   input  wire logic vbus_present,
   input  wire logic bat_ovp_fault,
   input  wire logic ico_started,
   input  wire logic detect_done,
   // same-clock controls from the rest of the register map
   input  wire logic reg_reset,
   input  wire logic stop_charge_on_watchdog,
   // controls to the charger
   output logic       charge_enable_bit,
   output logic       term_enable,
   output logic       high_impedance_enable,
   output logic       bat_discharge,
   output logic       input_optimizer_enable,
   output logic       ico_start_req,
   output logic [1:0] input_overvoltage_threshold,
   output logic       detect_req,
   output logic       hv_port_handshake_enable,
   output logic       hv_port_twelve_volt_enable,
   output logic       hv_port_nine_volt_enable,
   output logic [1:0] ship_fet_mode_command,
   output logic       ship_fet_go,
   output logic       watchdog_expired
);

   logic [1:0]           rst_sync_q;
   logic                 rst_n;
   logic [3:0]           pin_s1_q, pin_s2_q;
   logic                 vbus_prev_q;
   logic                 ovp_s, ico_s, det_s, plug_evt;
   logic [31:0]          div_q, div_d;
   logic                 tick_q, tick_d;
   logic [7:0]           c0_q, c0_d, c1_q, c1_d, c2_q, c2_d;
   logic                 reload_q, reload_d, auto_pend_q, auto_pend_d;
   logic [7:0]           reg_ptr, wr_data, rd_data;
   logic                 wr_stb, wr0, wr1, wr2;
   logic                 wd_load, wd_expire, ship_load, ship_expire;
   logic [CCR_TMR_W-1:0] ship_val;
   logic                 ship_wr;
   logic [17:0]          out_q, out_d;

   function automatic logic [CCR_TMR_W-1:0] wd_ticks(input logic [2:0] code);
      wd_ticks = CCR_TMR_W'(CCR_WD_PERIOD_MS[code] / CCR_TICK_MS);
   endfunction

   function automatic logic ship_cmd(input logic stb, input logic [7:0] data);
      ship_cmd = stb && (data[CCR_B_SHIP_LO +: 2] != CCR_SHIP_IDLE);
   endfunction

   // reserved bits always read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] r0,
                                           input logic [7:0] r1, input logic [7:0] r2);
      case (ptr)
         CCR_OFS_CTRL0: reg_read = r0 & CCR_WMASK_CTRL0;
         CCR_OFS_CTRL1: reg_read = r1 & CCR_WMASK_CTRL1;
         CCR_OFS_CTRL2: reg_read = r2 & CCR_WMASK_CTRL2;
         default:       reg_read = 8'h00;
      endcase
   endfunction

   // reset release and pin synchronisers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // status pins are asynchronous: two flops first
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q    <= 4'h0;
         pin_s2_q    <= 4'h0;
         vbus_prev_q <= 1'b0;
      end else begin
         pin_s1_q    <= {detect_done, ico_started, bat_ovp_fault, vbus_present};
         pin_s2_q    <= pin_s1_q;
         vbus_prev_q <= pin_s2_q[0];
      end
   end
   assign ovp_s    = pin_s2_q[1];
   assign ico_s    = pin_s2_q[2];
   assign det_s    = pin_s2_q[3];
   assign plug_evt = pin_s2_q[0] & ~vbus_prev_q;

   // half-second tick divider
   // free-running: a timeout may end up to one tick early
   always_comb begin
      tick_d = 1'b0;
      div_d  = div_q + 32'h0000_0001;
      if (div_q >= 32'(TICK_CYCLES - 1)) begin
         div_d  = 32'h0000_0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   ccr_i2c_slave u_bus (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_o    (sda_o),
      .sda_oe_n (sda_oe_n),
      .reg_ptr  (reg_ptr),
      .wr_stb   (wr_stb),
      .wr_data  (wr_data),
      .rd_data  (rd_data)
   );

   assign rd_data = reg_read(reg_ptr, c0_q, c1_q, c2_q);
   assign wr0     = wr_stb && (reg_ptr == CCR_OFS_CTRL0);
   assign wr1     = wr_stb && (reg_ptr == CCR_OFS_CTRL1);
   assign wr2     = wr_stb && (reg_ptr == CCR_OFS_CTRL2);

   // kick bit seen set restarts the timer; period writes reload it too
   // the kick bit reads back as one for a single cycle
   assign wd_load = c1_q[CCR_B_WD_KICK] | wd_expire | reload_q;

   ccr_timer u_wd (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .tick     (tick_q),
      .load     (wd_load),
      .load_val (wd_ticks(c1_q[CCR_B_WD_LO +: 3])),
      .expire   (wd_expire)
   );

   // delayed ship fet action; immediate path bypasses the timer
   // writing code zero later does not cancel a pending delay
   assign ship_wr   = ship_cmd(wr2, wr_data);
   assign ship_load = ship_wr && !wr_data[CCR_B_SHIP_SKIP];
   assign ship_val  = ship_load ? CCR_TMR_W'(CCR_SHIP_DELAY_TICK) : '0;

   ccr_timer u_ship (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .tick     (tick_q),
      .load     (ship_load | reg_reset),
      .load_val (ship_val),
      .expire   (ship_expire)
   );

   // register next state: device clears first, bus writes after so a set wins
   always_comb begin
      c0_d        = c0_q;
      c1_d        = c1_q;
      c2_d        = c2_q;
      auto_pend_d = auto_pend_q;
      reload_d    = wr1;
      if (wd_expire) begin
         // register-reset-only fields keep their values
         if (stop_charge_on_watchdog) begin
            c0_d[CCR_B_CHG_EN] = 1'b0;
         end
         c0_d[CCR_B_ICO_FORCE] = CCR_RST_CTRL0[CCR_B_ICO_FORCE];
         c0_d[CCR_B_TERM_EN]   = CCR_RST_CTRL0[CCR_B_TERM_EN];
         c1_d[CCR_B_WD_KICK]   = CCR_RST_CTRL1[CCR_B_WD_KICK];
         c2_d[CCR_B_DET_FORCE] = CCR_RST_CTRL2[CCR_B_DET_FORCE];
         c2_d[CCR_B_DET_AUTO]  = CCR_RST_CTRL2[CCR_B_DET_AUTO];
      end
      if (ico_s) begin
         c0_d[CCR_B_ICO_FORCE] = 1'b0;
      end
      if (plug_evt) begin
         c0_d[CCR_B_HIZ_EN] = 1'b0;
         if (c2_q[CCR_B_DET_AUTO]) begin
            auto_pend_d = 1'b1;
         end
      end
      if (det_s) begin
         c2_d[CCR_B_DET_FORCE] = 1'b0;
         if (!plug_evt) begin
            auto_pend_d = 1'b0;
         end
      end
      if (c1_q[CCR_B_WD_KICK]) begin
         c1_d[CCR_B_WD_KICK] = 1'b0;
      end
      if (wr0) begin
         // writing zero never clears the optimizer force bit
         c0_d = (wr_data & CCR_WMASK_CTRL0) | (c0_d & (8'h01 << CCR_B_ICO_FORCE));
      end
      if (wr1) begin
         c1_d = wr_data & CCR_WMASK_CTRL1;
      end
      if (wr2) begin
         c2_d = wr_data & CCR_WMASK_CTRL2;
      end
      // register reset outranks writes and device clears
      if (reg_reset) begin
         c0_d        = CCR_RST_CTRL0;
         c1_d        = CCR_RST_CTRL1;
         c2_d        = CCR_RST_CTRL2;
         auto_pend_d = 1'b0;
         reload_d    = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         c0_q        <= CCR_RST_CTRL0;
         c1_q        <= CCR_RST_CTRL1;
         c2_q        <= CCR_RST_CTRL2;
         auto_pend_q <= 1'b0;
         reload_q    <= 1'b1;
      end else begin
         c0_q        <= c0_d;
         c1_q        <= c1_d;
         c2_q        <= c2_d;
         auto_pend_q <= auto_pend_d;
         reload_q    <= reload_d;
      end
   end

   // registered outputs
   always_comb begin
      out_d[0]     = c0_q[CCR_B_CHG_EN];
      out_d[1]     = c0_q[CCR_B_TERM_EN];
      out_d[2]     = c0_q[CCR_B_HIZ_EN];
      out_d[3]     = c0_q[CCR_B_FORCE_DISCHG] | (c0_q[CCR_B_AUTO_DISCHG] & ovp_s);
      out_d[4]     = c0_q[CCR_B_ICO_EN];
      out_d[5]     = c0_q[CCR_B_ICO_FORCE] & c0_q[CCR_B_ICO_EN];
      out_d[7:6]   = c1_q[CCR_B_OVP_LO +: 2];
      out_d[8]     = c2_q[CCR_B_DET_FORCE] | auto_pend_q;
      out_d[9]     = c2_q[CCR_B_HV_EN];
      out_d[10]    = c2_q[CCR_B_HV_12V];
      out_d[11]    = c2_q[CCR_B_HV_9V];
      out_d[13:12] = c2_q[CCR_B_SHIP_LO +: 2];
      out_d[14]    = ship_expire | (ship_wr && wr_data[CCR_B_SHIP_SKIP]);
      out_d[15]    = wd_expire;
      out_d[17:16] = 2'h0;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // only charge and termination enables reset high
         out_q <= 18'h0_0003;
      end else begin
         out_q <= out_d;
      end
   end

   assign charge_enable_bit           = out_q[0];
   assign term_enable                 = out_q[1];
   assign high_impedance_enable       = out_q[2];
   assign bat_discharge               = out_q[3];
   assign input_optimizer_enable      = out_q[4];
   assign ico_start_req               = out_q[5];
   assign input_overvoltage_threshold = out_q[7:6];
   assign detect_req                  = out_q[8];
   assign hv_port_handshake_enable    = out_q[9];
   assign hv_port_twelve_volt_enable  = out_q[10];
   assign hv_port_nine_volt_enable    = out_q[11];
   assign ship_fet_mode_command       = out_q[13:12];
   assign ship_fet_go                 = out_q[14];
   assign watchdog_expired            = out_q[15];

endmodule

// *** tb/ccr_top_sva.sv ***
// assertion checker on the charger control register bank ports
module ccr_top_sva
   import ccr_pkg::*;
#(
   parameter int TICK_CYCLES = CCR_TICK_CYCLES
) (
   // clock, reset and bus
   input wire logic       ref_clk,
   input wire logic       arst_n,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n,
   // status pins and controls
   input wire logic       vbus_present,
   input wire logic       bat_ovp_fault,
   input wire logic       ico_started,
   input wire logic       detect_done,
   input wire logic       reg_reset,
   input wire logic       stop_charge_on_watchdog,
   // charger controls
   input wire logic       charge_enable_bit,
   input wire logic       term_enable,
   input wire logic       high_impedance_enable,
   input wire logic       bat_discharge,
   input wire logic       input_optimizer_enable,
   input wire logic       ico_start_req,
   input wire logic [1:0] input_overvoltage_threshold,
   input wire logic       detect_req,
   input wire logic       hv_port_handshake_enable,
   input wire logic       hv_port_twelve_volt_enable,
   input wire logic       hv_port_nine_volt_enable,
   input wire logic [1:0] ship_fet_mode_command,
   input wire logic       ship_fet_go,
   input wire logic       watchdog_expired
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_hiz_plug; $rose(vbus_present) |-> ##[1:8] !high_impedance_enable; endproperty
   a_hiz_plug: assert property (p_hiz_plug) else $error("hiz kept after plug-in");
   property p_regrst; reg_reset |-> ##[1:3] (charge_enable_bit && term_enable && !high_impedance_enable
      && !input_optimizer_enable && input_overvoltage_threshold == CCR_OVP_26V
      && ship_fet_mode_command == CCR_SHIP_IDLE && !hv_port_handshake_enable); endproperty
   a_regrst: assert property (p_regrst) else $error("register reset values wrong");
   property p_ico_req; ico_start_req |-> input_optimizer_enable; endproperty
   a_ico_req: assert property (p_ico_req) else $error("optimizer start while disabled");
   property p_ico_clr; ico_started && ico_start_req |-> ##[1:6] !ico_start_req; endproperty
   a_ico_clr: assert property (p_ico_clr) else $error("optimizer force not cleared");
   property p_det_done; detect_done && detect_req |-> ##[1:8] !detect_req; endproperty
   a_det_done: assert property (p_det_done) else $error("detection request stuck");
   property p_wd_term; watchdog_expired |-> ##[0:3] term_enable; endproperty
   a_wd_term: assert property (p_wd_term) else $error("termination not restored");
   property p_wd_stop; watchdog_expired && stop_charge_on_watchdog |-> ##[0:3] !charge_enable_bit; endproperty
   a_wd_stop: assert property (p_wd_stop) else $error("charge not stopped on expiry");
   property p_go_pulse; ship_fet_go |=> !ship_fet_go; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("ship action not a pulse");

   c_wd: cover property (watchdog_expired);
   c_go: cover property (ship_fet_go);
   c_det: cover property (detect_req ##[1:8] !detect_req);
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the charger control register bank
module testbench
   import ccr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // tick shortened so slow timers fit the run
   localparam int T = 100;
   localparam int Q = 6;
   logic       ref_clk = 0, arst_n = 0, scl_i = 1, m_sda = 1;
   logic       vbus_present = 0, bat_ovp_fault = 0, ico_started = 0, detect_done = 0;
   logic       reg_reset = 0, stop_charge_on_watchdog = 0;
   logic       sda_o, sda_oe_n, charge_enable_bit, term_enable, high_impedance_enable, bat_discharge;
   logic       input_optimizer_enable, ico_start_req, detect_req, hv_port_handshake_enable;
   logic       hv_port_twelve_volt_enable, hv_port_nine_volt_enable, ship_fet_go, watchdog_expired;
   logic [1:0] input_overvoltage_threshold, ship_fet_mode_command;
   logic [7:0] exp_q[$], got_q[$], d;
   int         num_errors = 0, checks_done = 0, cyc = 0, gos = 0, wds = 0, seed = 55, g0;
   // open drain: low when the device pulls, else pulled up unless the master pulls
   wire logic       sda_i = m_sda & (sda_oe_n | sda_o);
   wire logic [7:0] outs = {charge_enable_bit, term_enable, high_impedance_enable, input_optimizer_enable,
                            ico_start_req, detect_req, bat_discharge, hv_port_handshake_enable};

   ccr_top #(.TICK_CYCLES(T)) DUT (.*);

   always #4 ref_clk = ~ref_clk;

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(negedge ref_clk) begin
      cyc <= cyc + 1;
      if (ship_fet_go === 1'b1) gos <= gos + 1;
      if (watchdog_expired === 1'b1) wds <= wds + 1;
      if (cyc == 90000) begin
         num_errors++;
         end_sim();
      end
   end

   always begin
      wait (got_q.size() > 0);
      checks_done++;
      if (got_q[0] !== exp_q[0]) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
   end

   task automatic cmp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      got_q.push_back(a);
   endtask

   task automatic pause(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic bit_x(input logic b, output logic r);
      m_sda = b;
      pause(Q);
      scl_i = 1;
      pause(Q);
      r = sda_i;
      scl_i = 0;
      pause(Q);
   endtask

   task automatic start();
      m_sda = 1;
      pause(Q);
      scl_i = 1;
      pause(Q);
      m_sda = 0;
      pause(Q);
      scl_i = 0;
      pause(Q);
   endtask

   task automatic stop();
      m_sda = 0;
      pause(Q);
      scl_i = 1;
      pause(Q);
      m_sda = 1;
      pause(Q);
   endtask

   // last byte of a read is left unacknowledged
   task automatic byte_x(input logic [7:0] b, input logic last, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
      bit_x(1'b1, a);
      if (!last) cmp({7'h0, a}, 8'h00);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      logic [7:0] r;
      start();
      byte_x({CCR_DEV_ADDR, 1'b0}, 1'b0, r);
      byte_x(p, 1'b0, r);
      byte_x(v, 1'b0, r);
      stop();
      pause(4);
   endtask

   task automatic chk(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] r;
      start();
      byte_x({CCR_DEV_ADDR, 1'b0}, 1'b0, r);
      byte_x(p, 1'b0, r);
      start();
      byte_x({CCR_DEV_ADDR, 1'b1}, 1'b0, r);
      byte_x(8'hff, 1'b1, r);
      stop();
      cmp(r, e);
   endtask

   initial begin
      pause(20);
      arst_n = 1;
      pause(10);
      chk(CCR_OFS_CTRL0, CCR_RST_CTRL0);
      chk(CCR_OFS_CTRL1, CCR_RST_CTRL1 & CCR_WMASK_CTRL1);
      chk(CCR_OFS_CTRL2, CCR_RST_CTRL2);
      cmp(outs, 8'hc0);
      chk(8'h12, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(CCR_OFS_CTRL1, 8'(c << 4));
         cmp(8'(input_overvoltage_threshold), 8'(c));
      end
      repeat (3) begin
         d = 8'($random(seed)) & 8'h79;
         wr(CCR_OFS_CTRL2, d);
         chk(CCR_OFS_CTRL2, d);
         cmp(8'({hv_port_twelve_volt_enable, hv_port_nine_volt_enable, hv_port_handshake_enable}), 8'(d[5:3]));
      end
      bat_ovp_fault = 1;
      pause(8);
      cmp(8'(bat_discharge), 8'h01);
      wr(CCR_OFS_CTRL0, 8'h22);
      cmp(8'(bat_discharge), 8'h00);
      bat_ovp_fault = 0;
      wr(CCR_OFS_CTRL0, 8'h62);
      cmp(8'(bat_discharge), 8'h01);
      wr(CCR_OFS_CTRL0, 8'h28);
      cmp(8'(ico_start_req), 8'h00);
      wr(CCR_OFS_CTRL0, 8'h38);
      cmp(8'(ico_start_req), 8'h01);
      ico_started = 1;
      pause(8);
      ico_started = 0;
      chk(CCR_OFS_CTRL0, 8'h30);
      wr(CCR_OFS_CTRL0, 8'h24);
      wr(CCR_OFS_CTRL2, 8'h40);
      vbus_present = 1;
      pause(10);
      cmp(8'({high_impedance_enable, detect_req}), 8'h01);
      detect_done = 1;
      pause(10);
      detect_done = 0;
      wr(CCR_OFS_CTRL2, 8'hc0);
      cmp(8'(detect_req), 8'h01);
      detect_done = 1;
      pause(10);
      detect_done = 0;
      chk(CCR_OFS_CTRL2, 8'h40);
      vbus_present = 0;
      wr(CCR_OFS_CTRL2, 8'h00);
      vbus_present = 1;
      pause(10);
      cmp(8'(detect_req), 8'h00);
      for (int c = 1; c < 4; c++) begin
         g0 = gos;
         wr(CCR_OFS_CTRL2, 8'(c * 2 + 1));
         cmp(8'(ship_fet_mode_command), 8'(c));
         cmp(8'(gos - g0), 8'h01);
      end
      g0 = gos;
      wr(CCR_OFS_CTRL2, 8'h04);
      pause(18 * T);
      cmp(8'(gos - g0), 8'h00);
      pause(3 * T);
      cmp(8'(gos - g0), 8'h01);
      wr(CCR_OFS_CTRL0, 8'h00);
      g0 = wds;
      wr(CCR_OFS_CTRL1, 8'h31);
      pause(2 * T);
      cmp(8'(wds > g0), 8'h01);
      cmp(8'({charge_enable_bit, term_enable}), 8'h01);
      cmp(8'(input_overvoltage_threshold), 8'h03);
      // term kept set so a write colliding with an expiry cannot look like a missed restore
      wr(CCR_OFS_CTRL0, 8'h22);
      pause(4 * T);
      cmp(8'(charge_enable_bit), 8'h01);
      stop_charge_on_watchdog = 1;
      pause(2 * T);
      cmp(8'(charge_enable_bit), 8'h00);
      wr(CCR_OFS_CTRL1, 8'h0c);
      chk(CCR_OFS_CTRL1, 8'h04);
      reg_reset = 1;
      pause(1);
      reg_reset = 0;
      pause(4);
      cmp(outs, 8'hc0);
      chk(CCR_OFS_CTRL2, CCR_RST_CTRL2);
      pause(2);
      end_sim();
   end
endmodule

bind ccr_top ccr_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
